// file: design/adc_host_pkg.sv
// Purpose: shared constants and types of the converter host controller
// Assumes: 125 MHz system clock, 32-bit register bus
// Notes:   serial frame timing counts derive from the times below
package adc_host_pkg;

  localparam int CLK_PERIOD_NS   = 8;
  localparam int SER_PERIOD_NS   = 64;
  localparam int HALF_CYCLES     = SER_PERIOD_NS / 2 / CLK_PERIOD_NS;
  localparam int GAP_NS          = 64;
  localparam int GAP_CYCLES      = GAP_NS / CLK_PERIOD_NS;

  localparam int WORD_W          = 14;
  localparam int INSTR_W         = 16;
  localparam int BYTE_W          = 8;
  localparam logic [5:0] INSTR_BITS = 6'h10;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] CMD_OFS     = 8'h04;
  localparam logic [7:0] TXDATA_OFS  = 8'h08;
  localparam logic [7:0] RXDATA_OFS  = 8'h0C;
  localparam logic [7:0] STATUS_OFS  = 8'h10;
  localparam logic [7:0] SAMPLE_OFS  = 8'h14;

  // control register fields
  localparam int CTRL_START       = 0;
  localparam int CTRL_STRAP_MODE  = 1;
  localparam int CTRL_STRAP_FMT   = 2;
  localparam int CTRL_STRAP_STAB  = 3;
  localparam int CTRL_LSB_FIRST   = 4;
  localparam int CTRL_STALL       = 5;
  localparam int CTRL_CAP_INVERT  = 6;
  localparam int CTRL_OUT_DISABLE = 7;
  localparam logic [7:0] CTRL_RESET = 8'h0A;

  // command register fields
  localparam int CMD_ADDR_LSB  = 0;
  localparam int CMD_LEN_LSB   = 13;
  localparam int CMD_READ      = 15;
  localparam int CMD_COUNT_LSB = 16;
  localparam logic [17:0] CMD_RESET = 18'h00000;
  localparam logic [1:0]  LEN_STREAM = 2'h3;

  // status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;

  typedef enum logic [4:0] {
    SER_IDLE   = 5'b00001,
    SER_SETUP  = 5'b00010,
    SER_SHIFT  = 5'b00100,
    SER_GAP    = 5'b01000,
    SER_FINISH = 5'b10000
  } serState_t;

endpackage

// file: design/capture_if.sv
// Purpose: carries sample pins, capture control and captured sample
// Assumes: one system clock on both ends
// Notes:   pins arrive raw; the capture end synchronises them
`timescale 1ns/10ps
interface capture_if;
  logic        captureClock;
  logic [13:0] sampleWord;
  logic        rangeFlag;
  logic        invertEdge;
  logic [13:0] heldWord;
  logic        heldFlag;
  logic        underRange;
  logic        overRange;
  logic [15:0] sampleCount;

  modport host (output captureClock, sampleWord, rangeFlag, invertEdge,
                input  heldWord, heldFlag, underRange, overRange, sampleCount);
  modport cap  (input  captureClock, sampleWord, rangeFlag, invertEdge,
                output heldWord, heldFlag, underRange, overRange, sampleCount);
endinterface

// file: design/sample_capture.sv
// Purpose: receives converter output words on the capture clock edge
// Assumes: capture clock well below half the system clock rate
// Notes:   all pins pass two flip-flops before use
`timescale 1ns/10ps
module sample_capture
  import adc_host_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  capture_if.cap   cap
);

  typedef struct packed {
    logic [1:0]  clkSync;
    logic        clkPrev;
    logic [13:0] wordMeta;
    logic [13:0] wordSync;
    logic        flagMeta;
    logic        flagSync;
    logic [13:0] word;
    logic        flag;
    logic        under;
    logic        over;
    logic [15:0] count;
  } capState_t;

  capState_t state;
  capState_t next_state;
  logic      activeEdge;

  always_comb begin
    next_state = state;
    next_state.clkSync  = {state.clkSync[0], cap.captureClock};
    next_state.clkPrev  = state.clkSync[1];
    next_state.wordMeta = cap.sampleWord;
    next_state.wordSync = state.wordMeta;
    next_state.flagMeta = cap.rangeFlag;
    next_state.flagSync = state.flagMeta;
    // polarity follows the capture inversion bit of the host control register
    activeEdge = cap.invertEdge ? (state.clkPrev & ~state.clkSync[1])
                                : (~state.clkPrev & state.clkSync[1]);
    if (activeEdge) begin
      next_state.word  = state.wordSync;
      next_state.flag  = state.flagSync;
      next_state.under = state.flagSync & ~state.wordSync[WORD_W-1];
      next_state.over  = state.flagSync & state.wordSync[WORD_W-1];
      next_state.count = state.count + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign cap.heldWord    = state.word;
  assign cap.heldFlag    = state.flag;
  assign cap.underRange  = state.under;
  assign cap.overRange   = state.over;
  assign cap.sampleCount = state.count;

endmodule

// file: design/adc_host_ctrl.sv
// Purpose: host for a 14-bit converter: serial configuration master,
//          pin-strap driver and output word capture, run from APB
// Assumes: device samples serial data on the rising serial clock edge
// Notes:   zero-wait APB slave; one serial frame in flight at a time
//
// Function
// - flag with top bit gives under or over
// - capture data on active capture clock edge
// - frame starts select low then rising clock
// - data stable around rising serial clock edge
// - select may stay low for streaming
// - select may rise between bytes to stall
// - frame opens with 16-bit instruction
// - data phases are whole bytes only
// - host releases data pin for read data
// - select held high when port unused
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module adc_host_ctrl
  import adc_host_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             serialClockFormatPin,
  input  wire logic        serialIoStabilizerPinIn,
  output logic             serialIoStabilizerPinOut,
  output logic             serialIoStabilizerPinEnN,
  output logic             portSelectLow,
  output logic             outputDriveDisableN,
  input  wire logic        dataCaptureClock,
  input  wire logic [13:0] sampleWord,
  input  wire logic        rangeFlag
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [17:0] cmd;
    logic [31:0] tx;
    logic [31:0] rx;
    logic        done;
    serState_t   ser;
    logic [3:0]  phase;
    logic [5:0]  pos;
    logic [5:0]  lastPos;
    logic [1:0]  ioSync;
    logic        sclk;
    logic        sdo;
    logic        sdoEnN;
    logic        selLow;
    logic [31:0] rdata;
    logic        err;
  } hostState_t;

  hostState_t state;
  hostState_t next_state;

  capture_if capBus ();

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // bit index of frame position inside its own field (instruction or data)
  function automatic logic [4:0] fieldIndex(input logic [5:0] pos,
                                            input logic       lsb);
    logic [5:0] d;
    d = pos - INSTR_BITS;
    if (pos < INSTR_BITS) begin
      fieldIndex = lsb ? {1'b0, pos[3:0]} : {1'b0, 4'hF - pos[3:0]};
    end else begin
      fieldIndex = lsb ? d[4:0] : {d[4:3], 3'h7 - d[2:0]};
    end
  endfunction

  function automatic logic frameBit(input logic [15:0] instr,
                                    input logic [31:0] data,
                                    input logic [5:0]  pos,
                                    input logic        lsb);
    logic [4:0] idx;
    idx = fieldIndex(pos, lsb);
    if (pos < INSTR_BITS) begin
      frameBit = instr[idx[3:0]];
    end else begin
      frameBit = data[idx];
    end
  endfunction

  function automatic logic [5:0] frameLast(input logic [17:0] cmd);
    logic [2:0] bytes;
    // length code three streams the programmed count plus one bytes
    if (cmd[CMD_LEN_LSB+:2] == LEN_STREAM) begin
      bytes = {1'b0, cmd[CMD_COUNT_LSB+:2]} + 3'h1;
    end else begin
      bytes = {1'b0, cmd[CMD_LEN_LSB+:2]} + 3'h1;
    end
    frameLast = INSTR_BITS + {bytes, 3'h0} - 6'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // main process

  logic [15:0] instr;
  logic        lsbFirst;
  logic        isRead;
  logic        apbWrite;
  logic        apbSetup;
  logic        byteEnd;

  always_comb begin
    next_state = state;
    // read flag leads, then length pair, then address
    instr    = {state.cmd[CMD_READ], state.cmd[CMD_LEN_LSB+:2],
                state.cmd[CMD_ADDR_LSB+:13]};
    lsbFirst = state.ctrl[CTRL_LSB_FIRST];
    isRead   = state.cmd[CMD_READ];
    apbWrite = psel & penable & pwrite;
    apbSetup = psel & ~penable;
    byteEnd  = (state.pos >= INSTR_BITS - 6'h01) && (state.pos[2:0] == 3'h7);

    next_state.ioSync = {state.ioSync[0], serialIoStabilizerPinIn};
    next_state.ctrl[CTRL_START] = 1'b0;

    // register writes take effect in the access phase
    if (apbWrite) begin
      unique case (paddr)
        CTRL_OFS:   next_state.ctrl = pwdata[7:0];
        CMD_OFS:    next_state.cmd  = state.ser == SER_IDLE ? pwdata[17:0] : state.cmd;
        TXDATA_OFS: next_state.tx   = state.ser == SER_IDLE ? pwdata : state.tx;
        STATUS_OFS: next_state.done = state.done & ~pwdata[STAT_DONE];
        default: begin
        end
      endcase
    end

    unique case (state.ser)
      SER_IDLE: begin
        next_state.phase = 4'h0;
        next_state.pos   = 6'h00;
        next_state.selLow = 1'b0;
        // unused port: select high, shared pins carry strap levels
        if (state.ctrl[CTRL_STRAP_MODE]) begin
          next_state.sclk   = state.ctrl[CTRL_STRAP_FMT];
          next_state.sdo    = state.ctrl[CTRL_STRAP_STAB];
          next_state.sdoEnN = 1'b0;
        end else begin
          next_state.sclk   = 1'b0;
          next_state.sdoEnN = 1'b1;
        end
        // start is ignored while strapping, busy frames never get here
        if (state.ctrl[CTRL_START] && !state.ctrl[CTRL_STRAP_MODE]) begin
          next_state.ser     = SER_SETUP;
          next_state.lastPos = frameLast(state.cmd);
          next_state.rx      = '0;
          next_state.sclk    = 1'b0;
          next_state.selLow  = 1'b1;
          next_state.sdo     = frameBit(instr, state.tx, 6'h00, lsbFirst);
          next_state.sdoEnN  = 1'b0;
        end
      end

      SER_SETUP: begin
        // select low with clock low for a full period before first rise
        next_state.phase = state.phase + 4'h1;
        if (state.phase == 4'(HALF_CYCLES - 1)) begin
          next_state.ser   = SER_SHIFT;
          next_state.phase = 4'h0;
        end
      end

      SER_SHIFT: begin
        next_state.phase = state.phase + 4'h1;
        // clock high in second half of each bit, data set while low
        if (state.phase == 4'(HALF_CYCLES - 1)) begin
          next_state.sclk = 1'b1;
        end
        if (state.phase == 4'(2 * HALF_CYCLES - 1)) begin
          next_state.phase = 4'h0;
          next_state.sclk  = 1'b0;
          // synced pin lags two cycles, still inside the high phase
          if (isRead && state.pos >= INSTR_BITS) begin
            next_state.rx[fieldIndex(state.pos, lsbFirst)] = state.ioSync[1];
          end
          if (state.pos == state.lastPos) begin
            next_state.ser = SER_FINISH;
          end else begin
            next_state.pos = state.pos + 6'h01;
            next_state.sdo = frameBit(instr, state.tx, state.pos + 6'h01, lsbFirst);
            // release the pin once the instruction is out on a read
            next_state.sdoEnN = isRead && (state.pos + 6'h01 >= INSTR_BITS);
            // optional stall: select rises only at a byte boundary
            if (state.ctrl[CTRL_STALL] && byteEnd) begin
              next_state.ser    = SER_GAP;
              next_state.selLow = 1'b0;
            end
          end
        end
      end

      SER_GAP: begin
        next_state.phase = state.phase + 4'h1;
        if (state.phase == 4'(GAP_CYCLES - 1)) begin
          next_state.ser    = SER_SETUP;
          next_state.phase  = 4'h0;
          next_state.selLow = 1'b1;
        end
      end

      SER_FINISH: begin
        // hold select low a full period after the last rising edge
        next_state.phase = state.phase + 4'h1;
        if (state.phase == 4'(HALF_CYCLES - 1)) begin
          next_state.ser    = SER_IDLE;
          next_state.selLow = 1'b0;
          next_state.sdoEnN = 1'b1;
          next_state.done   = 1'b1;
        end
      end
    endcase

    // read data registered in the setup phase, ready in the access phase
    if (apbSetup) begin
      next_state.err = 1'b0;
      unique case (paddr)
        CTRL_OFS:   next_state.rdata = {24'h000000, state.ctrl};
        CMD_OFS:    next_state.rdata = {14'h0000, state.cmd};
        TXDATA_OFS: next_state.rdata = state.tx;
        RXDATA_OFS: next_state.rdata = state.rx;
        STATUS_OFS: next_state.rdata = {30'h00000000, state.done, state.ser != SER_IDLE};
        SAMPLE_OFS: next_state.rdata = {2'h0, capBus.sampleCount[12:0], capBus.overRange,
                                        capBus.underRange, capBus.heldFlag,
                                        capBus.heldWord};
        default: begin
          next_state.rdata = 32'h00000000;
          next_state.err   = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state        <= '0;
      state.ctrl   <= CTRL_RESET;
      state.cmd    <= CMD_RESET;
      state.ser    <= SER_IDLE;
      state.sdoEnN <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture side

  assign capBus.captureClock = dataCaptureClock;
  assign capBus.sampleWord   = sampleWord;
  assign capBus.rangeFlag    = rangeFlag;
  assign capBus.invertEdge   = state.ctrl[CTRL_CAP_INVERT];

  sample_capture capture (
    .clk   (clk),
    .reset (reset),
    .cap   (capBus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata                   = state.rdata;
  assign pready                   = 1'b1;
  assign pslverr                  = state.err & psel & penable;
  assign serialClockFormatPin     = state.sclk;
  assign serialIoStabilizerPinOut = state.sdo;
  assign serialIoStabilizerPinEnN = state.sdoEnN;
  assign portSelectLow            = ~state.selLow;
  assign outputDriveDisableN      = state.ctrl[CTRL_OUT_DISABLE];

endmodule

// file: dv/adc_host_asserts.sv
// Purpose: port checks of the converter host controller
// Assumes: serial half period of four clocks
// Notes:   bound into adc_host_ctrl
`timescale 1ns/10ps
module adc_host_asserts (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        serialClockFormatPin,
  input wire logic        serialIoStabilizerPinOut,
  input wire logic        serialIoStabilizerPinEnN,
  input wire logic        portSelectLow,
  input wire logic        outputDriveDisableN
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////
  // a select gap longer than a stall closes the frame
  logic [3:0] hiCnt;
  logic [5:0] riseCnt;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hiCnt   <= 4'h0;
      riseCnt <= 6'h00;
    end else begin
      hiCnt <= !portSelectLow ? 4'h0 : hiCnt + {3'h0, hiCnt != 4'hF};
      if (hiCnt > 4'h9)
        riseCnt <= 6'h00;
      else if (!portSelectLow && serialClockFormatPin && !$past(serialClockFormatPin))
        riseCnt <= riseCnt + 6'h01;
    end
  end
  ////////////////////////////////////////////////////////////
  sel_setup_a: assert property ($fell(portSelectLow) |-> !serialClockFormatPin [*4])
    else $error("serial clock rose within setup");
  clk_high_a: assert property (!portSelectLow && $rose(serialClockFormatPin) |->
    serialClockFormatPin [*4] ##1 !serialClockFormatPin) else $error("serial clock high phase wrong");
  data_hold_a: assert property (!portSelectLow && !serialIoStabilizerPinEnN && serialClockFormatPin |->
    $stable(serialIoStabilizerPinOut)) else $error("data moved while clock high");
  pin_release_a: assert property (!portSelectLow && $rose(serialIoStabilizerPinEnN) |->
    riseCnt > 6'hF && riseCnt[2:0] == 3'h0) else $error("data pin released off boundary");
  whole_bytes_a: assert property (hiCnt == 4'h9 |-> riseCnt == 6'h00 ||
    riseCnt > 6'h17 && riseCnt[2:0] == 3'h0) else $error("frame not instruction plus bytes");
  stall_point_a: assert property ($rose(portSelectLow) |->
    !serialClockFormatPin && riseCnt[2:0] == 3'h0) else $error("select rose inside a byte");
  idle_select_a: assert property ($fell(reset) |-> portSelectLow && !outputDriveDisableN)
    else $error("select not idle after reset");
  slverr_access_a: assert property (pslverr |-> psel && penable && prdata == 32'h00000000)
    else $error("error flag outside access phase");
  cover property (!portSelectLow && $rose(serialIoStabilizerPinEnN));
  cover property ($rose(portSelectLow) && riseCnt == 6'h10);
  cover property (pslverr);
endmodule
bind adc_host_ctrl adc_host_asserts chk (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .prdata(prdata), .pslverr(pslverr), .serialClockFormatPin(serialClockFormatPin),
  .serialIoStabilizerPinOut(serialIoStabilizerPinOut), .serialIoStabilizerPinEnN(serialIoStabilizerPinEnN),
  .portSelectLow(portSelectLow), .outputDriveDisableN(outputDriveDisableN));

// file: dv/adc_device_model.sv
// Purpose: behavioural converter device facing the host controller
// Assumes: capture clock of 80 ns, msb first until the lsb bit is set
// Notes:   eight configuration bytes only; no gray coding
`timescale 1ns/10ps
module adc_device_model (
  input  wire logic               sclk,
  input  wire logic               sdio,
  output logic                    sdoOut,
  output logic                    sdoEnN,
  input  wire logic               selN,
  input  wire logic               por,
  input  wire logic               oeN,
  output logic                    capClk,
  output logic [13:0]             word,
  output logic                    orFlag,
  input  wire logic signed [15:0] level
);
  logic [7:0]  mem [0:7];
  logic [14:0] pipe [0:12];
  logic [15:0] instr;
  logic [7:0]  wsh;
  logic [7:0]  sh;
  logic        fmt;
  logic        drv;
  int          cnt;
  logic        lsb;
  function automatic logic [14:0] conv(input logic signed [15:0] v);
    logic signed [15:0] c;
    c = v > 16'sh1FFF ? 16'sh1FFF : (v < 16'shE000 ? 16'shE000 : v);
    return {v != c, fmt ? c[13] : ~c[13], c[12:0]};
  endfunction
  initial begin
    capClk = 1'b0;
    cnt = 0;
    drv = 1'b0;
    mem[0] = 8'h18;
    foreach (pipe[i]) pipe[i] = 15'h0000;
    forever #40 capClk = ~capClk;
  end
  always @(posedge capClk) begin
    for (int i = 12; i > 0; i--) pipe[i] = pipe[i - 1];
    pipe[0] = conv(level);
  end
  // released outputs show an inverted word, never a held one
  assign word   = oeN ? ~pipe[12][13:0] : pipe[12][13:0];
  assign orFlag = pipe[12][14];
  // bit order follows bit 6 of configuration byte 0
  assign lsb = mem[0][6];
  always @(negedge por) begin
    #50;
    fmt = sclk;
  end
  always @(posedge sclk) begin
    if (!selN) begin
      if (cnt < 16) instr = lsb ? {sdio, instr[15:1]} : {instr[14:0], sdio};
      else wsh = lsb ? {sdio, wsh[7:1]} : {wsh[6:0], sdio};
      cnt = cnt + 1;
      if (cnt == 16) sh = mem[instr[2:0]];
      if (cnt > 16 && (cnt - 16) % 8 == 0 && !instr[15]) mem[(instr[2:0] + (cnt - 17) / 8) % 8] = wsh;
    end
  end
  always @(negedge sclk) begin
    if (!selN && instr[15] && cnt >= 16) begin
      if (cnt > 16) sh = (cnt - 16) % 8 == 0 ? mem[(instr[2:0] + (cnt - 16) / 8) % 8]
                                             : (lsb ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0});
      drv = 1'b1;
    end
  end
  assign sdoOut = lsb ? sh[0] : sh[7];
  assign sdoEnN = !(drv && !selN);
  // a short high select is a stall; only a long one ends the frame
  always @(posedge selN) begin
    #100;
    if (selN) begin
      cnt = 0;
      drv = 1'b0;
    end
  end
endmodule

// file: dv/testbench.sv
// Purpose: self-checking bench of the converter host controller
// Assumes: device model answers on the shared serial pins
// Notes:   expectations follow the host register layout
`timescale 1ns/10ps
module testbench;
  import adc_host_pkg::*;
  logic               clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata;
  logic               sclk, sdoH, enH, sdoD, enD, flt, selN, drvOff, capClk, orFl;
  logic [13:0]        word;
  logic signed [15:0] level;
  wire                sdio;
  int                 errTotal, nCompared;
  // a released data line toggles so a missed turnaround shows
  assign sdio = !enH ? sdoH : (!enD ? sdoD : flt);
  adc_host_ctrl dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serialClockFormatPin(sclk),
    .serialIoStabilizerPinIn(sdio), .serialIoStabilizerPinOut(sdoH), .serialIoStabilizerPinEnN(enH),
    .portSelectLow(selN), .outputDriveDisableN(drvOff), .dataCaptureClock(capClk), .sampleWord(word),
    .rangeFlag(orFl));
  adc_device_model dev (.sclk(sclk), .sdio(sdio), .sdoOut(sdoD), .sdoEnN(enD), .selN(selN), .por(reset),
    .oeN(drvOff), .capClk(capClk), .word(word), .orFlag(orFl), .level(level));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) flt <= ~flt | reset;
  ////////////////////////////////////////////////////////////
  task automatic conclude;
    if (errTotal == 0 && nCompared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) begin
      errTotal++;
      conclude();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(a, 1'b1, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(a, 1'b0, 32'h00000000, q, e);
  endtask
  // one serial frame from start to the done flag, then clear it
  task automatic frame(input logic [31:0] ctl, input logic [31:0] cmd, input logic [31:0] tx);
    logic [31:0] q;
    int          n;
    wr(CTRL_OFS, ctl);
    wr(CMD_OFS, cmd);
    wr(TXDATA_OFS, tx);
    wr(CTRL_OFS, ctl | 32'h00000001);
    n = 0;
    do begin
      rd(STATUS_OFS, q);
      n++;
    end while (q[STAT_DONE] !== 1'b1 && n < 500);
    if (n >= 500) begin
      errTotal++;
      conclude();
    end
    wr(STATUS_OFS, 32'h00000002);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic sRegs;
    logic [31:0] q;
    logic        e;
    rd(CTRL_OFS, q);
    chk("ctrl reset", q, 32'h0000000A);
    chk("select idle", selN, 1'b1);
    chk("format strap", sclk, 1'b0);
    chk("stabilizer strap", sdio, 1'b1);
    apb(8'h20, 1'b0, 32'h00000000, q, e);
    chk("unmapped error", e, 1'b1);
    chk("unmapped data", q, 32'h00000000);
    wr(CTRL_OFS, 32'h0000008E);
    repeat (2) @(posedge clk);
    chk("format strap high", sclk, 1'b1);
    chk("drive disable", drvOff, 1'b1);
    chk("select held", selN, 1'b1);
    wr(CTRL_OFS, 32'h0000000A);
  endtask
  task automatic sWrite;
    frame(32'h00000000, 32'h00002003, 32'h0000A55A);
    chk("write byte0", dev.mem[3], 32'h0000005A);
    chk("write byte1", dev.mem[4], 32'h000000A5);
  endtask
  task automatic sRead;
    logic [31:0] q;
    frame(32'h00000000, 32'h0000A003, 32'h00000000);
    rd(RXDATA_OFS, q);
    chk("read back", q, 32'h0000A55A);
  endtask
  task automatic sStall;
    frame(32'h00000020, 32'h00026005, 32'h00112233);
    chk("stream byte0", dev.mem[5], 32'h00000033);
    chk("stream byte1", dev.mem[6], 32'h00000022);
    chk("stream byte2", dev.mem[7], 32'h00000011);
  endtask
  // device set to lsb-first, then a write and a read in that order
  task automatic sLsb;
    logic [31:0] q;
    frame(32'h00000000, 32'h00000000, 32'h00000042);
    chk("lsb config", dev.mem[0], 32'h00000042);
    frame(32'h00000010, 32'h00002001, 32'h0000C381);
    chk("lsb byte0", dev.mem[1], 32'h00000081);
    chk("lsb byte1", dev.mem[2], 32'h000000C3);
    frame(32'h00000010, 32'h0000A001, 32'h00000000);
    rd(RXDATA_OFS, q);
    chk("lsb read back", q, 32'h0000C381);
  endtask
  // old word must still stand well inside the twelve-cycle latency
  task automatic capStep(input logic signed [15:0] v, input logic [31:0] prev, input logic [31:0] exp);
    logic [31:0] q;
    level <= v;
    repeat (60) @(posedge clk);
    rd(SAMPLE_OFS, q);
    chk("sample early", q & 32'h0001FFFF, prev);
    repeat (150) @(posedge clk);
    rd(SAMPLE_OFS, q);
    chk("sample", q & 32'h0001FFFF, exp);
  endtask
  task automatic sCapture;
    capStep(16'sh4000, 32'h00002000, 32'h00017FFF);
    capStep(16'shC000, 32'h00017FFF, 32'h0000C000);
    capStep(16'sh0000, 32'h0000C000, 32'h00002000);
    wr(CTRL_OFS, 32'h0000004A);
    capStep(16'shC000, 32'h00002000, 32'h0000C000);
  endtask
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    level = 16'sh0000;
    errTotal = 0;
    nCompared = 0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    sRegs();
    sWrite();
    sRead();
    sStall();
    sLsb();
    sCapture();
    conclude();
  end
endmodule
